// ---- local_vector_table_and_timer.sv ----
// Local vector table entries, local inputs and the count-down timer
//
// Functional notes
// - Wide identifier bit selects eight or four bits
// - Specific EOI write acts only when enabled
// - Enable register writes pass only when enabled
// - Entry field layout; reserved bits read zero
// - Fixed vector below 16 raises illegal error
// - NMI ignores vector; SMI sends vector 00h
// - Message type decode: fixed, SMI, NMI, external
// - Pending bit until delivered, then request set for fixed messages
// - Remote flag set on level accept, EOI clears
// - Remote flag set holds further level requests
// - Trigger bit picks level; SMI/NMI always edge
// - Mask bit blocks reception of the source
// - Timer mode bit: periodic or one-shot
// - One-shot loads, counts down, interrupts at zero
// - Periodic reloads at zero and interrupts again
// - Live count register reads running timer value
// - Start count copied into live count
// - Divide code selects core clock divisor
// - Local input messages raise maskable local interrupts
// - Trigger bit counts for inputs only when fixed
// - Separate entry per local source
// - Entries reset to masked value
// - Software disable forces all masks set
`timescale 1ns/100ps
`default_nettype none
`include "lvt_defines.svh"

module local_vector_table_and_timer #(
   parameter int N_ENTRY = 3
) (
   // Clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   // Register port
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   input  wire logic [11:0]           reg_addr_i,
   input  wire logic [31:0]           reg_wdata_i,
   output logic [31:0]                reg_rdata_o,
   // Controller state from elsewhere
   input  wire logic                  sw_enable_i,
   input  wire logic [7:0]            raw_identifier_i,
   output logic [7:0]                 identifier_o,
   // Local input messages
   input  wire logic                  local_input_0_i,
   input  wire logic                  local_input_1_i,
   // End of interrupt
   input  wire logic                  eoi_valid_i,
   input  wire logic [7:0]            eoi_vector_i,
   output logic                       specific_end_of_interrupt_o,
   output logic [7:0]                 specific_eoi_vector_o,
   // Enable register writes
   output logic                       ier_wr_o,
   output logic [11:0]                ier_addr_o,
   output logic [31:0]                ier_wdata_o,
   // Core interrupt handler
   output logic                       deliver_valid_o,
   output vector_table_pkg::deliver_t deliver_o,
   input  wire logic                  deliver_ack_i,
   output logic                       request_pending_set_o,
   output logic [7:0]                 request_pending_vector_o,
   output logic                       illegal_vector_o
);
   import vector_table_pkg::*;

   // ********************
   // Registers
   // ********************
   // Full register word; only the stored fields are taken from it
   localparam logic [31:0] ENTRY_RESET_WORD = `ENTRY_RESET_VALUE;
   table_entry_t entry_ff [N_ENTRY];
   logic [N_ENTRY-1:0] delivery_pending_ff;
   logic [N_ENTRY-1:0] remote_request_flag_ff;
   logic [N_ENTRY-1:0] input_prev_ff;
   logic [2:0]  ext_ctl_ff;
   logic [3:0]  divider_ff;
   logic [31:0] start_count_value_ff;
   logic [31:0] live_count_value_ff;
   logic        running_ff;
   logic        expiry_ff;
   logic        out_valid_ff;
   logic [1:0]  out_idx_ff;
   logic [11:0] entry_off [N_ENTRY];

   logic [N_ENTRY-1:0] raw_req;
   logic [N_ENTRY-1:0] level_mode;
   logic [N_ENTRY-1:0] req;
   logic [N_ENTRY-1:0] accept;
   logic [N_ENTRY-1:0] illegal;
   logic [N_ENTRY-1:0] eoi_hit;
   logic [N_ENTRY-1:0] entry_wr;
   logic        start_wr;
   logic        tick;
   logic [2:0]  divide_code;
   logic        spec_eoi_fire;
   logic [1:0]  grant_idx;
   logic        grant_any;

   assign entry_off[0] = `OFF_TIMER_ENTRY;
   assign entry_off[1] = `OFF_INPUT0_ENTRY;
   assign entry_off[2] = `OFF_INPUT1_ENTRY;
   assign raw_req = {local_input_1_i, local_input_0_i, expiry_ff};
   assign start_wr = reg_wr_i && (reg_addr_i == `OFF_START_COUNT);
   assign divide_code = {divider_ff[`DIV_CODE_HI_BIT], divider_ff[1:0]};
   assign spec_eoi_fire = reg_wr_i && (reg_addr_i == `OFF_SPECIFIC_EOI)
                          && ext_ctl_ff[`XCTL_SPEC_EOI_BIT];

   // ********************
   // Extended control and identifier
   // ********************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ext_ctl_ff <= 3'h0;
      end else if (reg_wr_i && reg_addr_i == `OFF_EXT_CONTROL) begin
         ext_ctl_ff <= reg_wdata_i[2:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         identifier_o <= 8'h00;
      end else if (ext_ctl_ff[`XCTL_WIDE_ID_BIT]) begin
         identifier_o <= raw_identifier_i;
      end else begin
         identifier_o <= {4'h0, raw_identifier_i[3:0]};
      end
   end

   // Specific EOI and enable register write forwarding
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         specific_end_of_interrupt_o <= 1'b0;
         specific_eoi_vector_o       <= 8'h00;
         ier_wr_o                    <= 1'b0;
         ier_addr_o                  <= 12'h000;
         ier_wdata_o                 <= 32'h0000_0000;
      end else begin
         specific_end_of_interrupt_o <= spec_eoi_fire;
         if (spec_eoi_fire) begin
            specific_eoi_vector_o <= reg_wdata_i[7:0];
         end
         // Writes while disabled are dropped silently
         ier_wr_o <= reg_wr_i && ext_ctl_ff[`XCTL_IER_WR_BIT]
                     && reg_addr_i >= `OFF_IER_FIRST
                     && reg_addr_i <= `OFF_IER_LAST;
         ier_addr_o  <= reg_addr_i;
         ier_wdata_o <= reg_wdata_i;
      end
   end

   // ********************
   // Vector table entries
   // ********************
   genvar gi;
   generate
      for (gi = 0; gi < N_ENTRY; gi++) begin : g_entry
         assign entry_wr[gi] = reg_wr_i && (reg_addr_i == entry_off[gi]);
         // Timer source has no trigger choice; inputs only when fixed
         assign level_mode[gi] = (gi != 0) && entry_ff[gi].level_trigger_select
                                 && (entry_ff[gi].message_type == MSG_FIXED);
         assign req[gi] = level_mode[gi] ? raw_req[gi]
                          : (raw_req[gi] && !input_prev_ff[gi]);
         assign accept[gi] = req[gi] && !entry_ff[gi].mask
                             && !delivery_pending_ff[gi]
                             && !(level_mode[gi] && remote_request_flag_ff[gi])
                             && !illegal[gi];
         assign illegal[gi] = req[gi] && !entry_ff[gi].mask
                              && entry_ff[gi].message_type == MSG_FIXED
                              && entry_ff[gi].vector_number < `VECTOR_FIRST_LEGAL;
         assign eoi_hit[gi] = (eoi_valid_i && eoi_vector_i == entry_ff[gi].vector_number)
                              || (spec_eoi_fire
                                  && reg_wdata_i[7:0] == entry_ff[gi].vector_number);

         always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i) begin
               // A plain cast would keep only the low bits and lose the mask
               entry_ff[gi] <= {ENTRY_RESET_WORD[17:15], ENTRY_RESET_WORD[10:0]};
            end else begin
               if (entry_wr[gi]) begin
                  // Reserved bits are not stored, so they read back zero
                  entry_ff[gi] <= {reg_wdata_i[17:15], reg_wdata_i[10:0]};
               end
               if (!sw_enable_i) begin
                  entry_ff[gi].mask <= 1'b1;
               end
            end
         end

         always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i) begin
               remote_request_flag_ff[gi] <= 1'b0;
            end else if (accept[gi] && level_mode[gi]) begin
               remote_request_flag_ff[gi] <= 1'b1;
            end else if (eoi_hit[gi]) begin
               remote_request_flag_ff[gi] <= 1'b0;
            end
         end

         always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i) begin
               delivery_pending_ff[gi] <= 1'b0;
               input_prev_ff[gi]       <= 1'b0;
            end else begin
               input_prev_ff[gi] <= raw_req[gi];
               if (accept[gi]) begin
                  delivery_pending_ff[gi] <= 1'b1;
               end else if (out_valid_ff && deliver_ack_i && out_idx_ff == 2'(gi)) begin
                  delivery_pending_ff[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ********************
   // Delivery to the core
   // ********************
   always_comb begin
      grant_any = 1'b0;
      grant_idx = 2'h0;
      for (int i = N_ENTRY - 1; i >= 0; i--) begin
         if (delivery_pending_ff[i]) begin
            grant_any = 1'b1;
            grant_idx = 2'(i);
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         out_valid_ff <= 1'b0;
         out_idx_ff   <= 2'h0;
         deliver_o    <= '0;
      end else if (out_valid_ff) begin
         if (deliver_ack_i) begin
            out_valid_ff <= 1'b0;
         end
      end else if (grant_any) begin
         out_valid_ff <= 1'b1;
         out_idx_ff   <= grant_idx;
         deliver_o.message_type <= entry_ff[grant_idx].message_type;
         unique case (msg_type_t'(entry_ff[grant_idx].message_type))
            MSG_FIXED, MSG_EXTINT: begin
               deliver_o.vector_number <= entry_ff[grant_idx].vector_number;
            end
            MSG_SMI, MSG_NMI: begin
               deliver_o.vector_number <= 8'h00;
            end
            default: begin
               deliver_o.vector_number <= entry_ff[grant_idx].vector_number;
            end
         endcase
      end
   end
   assign deliver_valid_o = out_valid_ff;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         request_pending_set_o    <= 1'b0;
         request_pending_vector_o <= 8'h00;
         illegal_vector_o         <= 1'b0;
      end else begin
         // Only fixed messages own a request bit
         request_pending_set_o <= out_valid_ff && deliver_ack_i
                                  && deliver_o.message_type == MSG_FIXED;
         request_pending_vector_o <= deliver_o.vector_number;
         illegal_vector_o         <= |illegal;
      end
   end

   // ********************
   // Timer
   // ********************
   timer_prescaler #(
      .CNT_W         (7)
   ) u_prescaler (
      .sys_clk_i     (sys_clk_i),
      .rst_n_i       (rst_n_i),
      .restart_i     (start_wr),
      .divide_code_i (divide_code),
      .tick_o        (tick)
   );

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         divider_ff           <= 4'h0;
         start_count_value_ff <= 32'h0000_0000;
      end else begin
         if (reg_wr_i && reg_addr_i == `OFF_CLOCK_DIVIDER) begin
            divider_ff <= {reg_wdata_i[3], 1'b0, reg_wdata_i[1:0]};
         end
         if (start_wr) begin
            start_count_value_ff <= reg_wdata_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         live_count_value_ff <= 32'h0000_0000;
         running_ff          <= 1'b0;
         expiry_ff           <= 1'b0;
      end else begin
         expiry_ff <= 1'b0;
         if (start_wr) begin
            live_count_value_ff <= reg_wdata_i;
            running_ff          <= (reg_wdata_i != 32'h0000_0000);
         end else if (running_ff && tick) begin
            if (live_count_value_ff == 32'h0000_0001) begin
               expiry_ff <= 1'b1;
               if (entry_ff[0].timer_periodic_select) begin
                  // Reload in the same tick, so zero never shows
                  live_count_value_ff <= start_count_value_ff;
               end else begin
                  live_count_value_ff <= 32'h0000_0000;
                  running_ff          <= 1'b0;
               end
            end else begin
               live_count_value_ff <= live_count_value_ff - 32'h0000_0001;
            end
         end
      end
   end

   // ********************
   // Register read
   // ********************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         reg_rdata_o <= 32'h0000_0000;
         for (int i = 0; i < N_ENTRY; i++) begin
            if (reg_addr_i == entry_off[i]) begin
               reg_rdata_o <= {14'h0000, entry_ff[i].timer_periodic_select,
                               entry_ff[i].mask, entry_ff[i].level_trigger_select,
                               remote_request_flag_ff[i], 1'b0, delivery_pending_ff[i],
                               1'b0, entry_ff[i].message_type,
                               entry_ff[i].vector_number};
            end
         end
         unique case (reg_addr_i)
            `OFF_START_COUNT:   reg_rdata_o <= start_count_value_ff;
            `OFF_LIVE_COUNT:    reg_rdata_o <= live_count_value_ff;
            `OFF_CLOCK_DIVIDER: reg_rdata_o <= {28'h0000000, divider_ff};
            `OFF_EXT_CONTROL:   reg_rdata_o <= {29'h00000000, ext_ctl_ff};
            default: begin
            end
         endcase
      end
   end

   // ********************
   // Checks
   // ********************
   a_mask_blocks_accept: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      entry_ff[1].mask |-> !accept[1]) else $error("masked input accepted");

   a_illegal_vector_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      illegal[0] || illegal[1] || illegal[2] |=> illegal_vector_o)
      else $error("illegal vector not flagged");

   a_spec_eoi_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      specific_end_of_interrupt_o |-> $past(ext_ctl_ff[`XCTL_SPEC_EOI_BIT]))
      else $error("specific EOI while disabled");

   a_ier_write_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ier_wr_o |-> $past(ext_ctl_ff[`XCTL_IER_WR_BIT]) && $past(reg_wr_i))
      else $error("enable register write while disabled");

   a_remote_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      level_mode[1] && remote_request_flag_ff[1] |-> !accept[1])
      else $error("level request passed remote flag");

   a_oneshot_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      expiry_ff && !entry_ff[0].timer_periodic_select && !$past(start_wr)
      |-> live_count_value_ff == 32'h0000_0000 && !running_ff)
      else $error("one-shot timer kept counting");

   a_periodic_reload: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      running_ff && tick && !start_wr && live_count_value_ff == 32'h0000_0001
      && entry_ff[0].timer_periodic_select
      |=> live_count_value_ff == start_count_value_ff && running_ff && expiry_ff)
      else $error("periodic timer did not reload");

   a_start_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      start_wr |=> live_count_value_ff == $past(reg_wdata_i)
      && running_ff == ($past(reg_wdata_i) != 32'h0000_0000))
      else $error("start count not loaded");

   a_disable_masks: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !sw_enable_i |=> entry_ff[0].mask && entry_ff[1].mask && entry_ff[2].mask)
      else $error("mask clear while disabled");

   a_narrow_identifier: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !ext_ctl_ff[`XCTL_WIDE_ID_BIT] |=> identifier_o[7:4] == 4'h0)
      else $error("upper identifier bits used");

   c_timer_expiry: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      expiry_ff ##[1:300] expiry_ff);
   c_level_eoi: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      remote_request_flag_ff[1] ##[1:50] !remote_request_flag_ff[1]);
   c_delivery: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      deliver_valid_o && deliver_ack_i ##1 request_pending_set_o);

endmodule // local_vector_table_and_timer
`default_nettype wire

// ---- lvt_defines.svh ----
// Register offsets, field positions, reset values, vector limit and divide codes
`ifndef TABLE_DEFINES_SVH
`define TABLE_DEFINES_SVH

// ********************
// Register offsets
// ********************
`define OFF_TIMER_ENTRY    12'h320
`define OFF_INPUT0_ENTRY   12'h350
`define OFF_INPUT1_ENTRY   12'h360
`define OFF_START_COUNT    12'h380
`define OFF_LIVE_COUNT     12'h390
`define OFF_CLOCK_DIVIDER  12'h3E0
`define OFF_EXT_CONTROL    12'h410
`define OFF_SPECIFIC_EOI   12'h420
`define OFF_IER_FIRST      12'h480
`define OFF_IER_LAST       12'h4F0

// ********************
// Field positions
// ********************
`define XCTL_WIDE_ID_BIT   2
`define XCTL_SPEC_EOI_BIT  1
`define XCTL_IER_WR_BIT    0
`define ENTRY_PERIODIC_BIT 17
`define ENTRY_MASK_BIT     16
`define ENTRY_LEVEL_BIT    15
`define ENTRY_REMOTE_BIT   14
`define ENTRY_PENDING_BIT  12
`define DIV_CODE_HI_BIT    3

// ********************
// Reset values and limits
// ********************
`define ENTRY_RESET_VALUE  32'h0001_0000
`define VECTOR_FIRST_LEGAL 8'h10
`define DIV_BY_ONE_CODE    3'h7
`define DIV_MAX_CODE       3'h6

`endif

// ---- lvt_pkg.sv ----
// Types shared by the local vector table block
package vector_table_pkg;

   typedef enum logic [2:0] {
      MSG_FIXED  = 3'b000,
      MSG_SMI    = 3'b010,
      MSG_NMI    = 3'b100,
      MSG_EXTINT = 3'b111
   } msg_type_t;

   // Writable part of one vector table entry
   typedef struct packed {
      logic       timer_periodic_select;
      logic       mask;
      logic       level_trigger_select;
      logic [2:0] message_type;
      logic [7:0] vector_number;
   } table_entry_t;

   // One message handed to the core interrupt handler
   typedef struct packed {
      logic [2:0] message_type;
      logic [7:0] vector_number;
   } deliver_t;

endpackage

// ---- timer_prescaler.sv ----
// Core clock divider producing the timer count strobe
`timescale 1ns/100ps
`default_nettype none
`include "lvt_defines.svh"

module timer_prescaler #(
   parameter int CNT_W = 7
) (
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   // Control
   input  wire logic       restart_i,
   input  wire logic [2:0] divide_code_i,
   // Strobe
   output logic            tick_o
);

   logic [CNT_W-1:0] div_cnt_ff;
   logic [CNT_W-1:0] div_mask;

   // Code 0 keeps one bit (divide by 2), code 6 keeps seven (divide by 128)
   assign div_mask = {CNT_W{1'b1}} >> (`DIV_MAX_CODE - divide_code_i);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || restart_i) begin
         div_cnt_ff <= '0;
      end else begin
         div_cnt_ff <= div_cnt_ff + CNT_W'(1);
      end
   end

   always_comb begin
      if (divide_code_i == `DIV_BY_ONE_CODE) begin
         tick_o = 1'b1;
      end else begin
         tick_o = ((div_cnt_ff & div_mask) == div_mask);
      end
   end

endmodule // timer_prescaler
`default_nettype wire

// ---- core_handler_model.sv ----
// Core interrupt handler model that accepts offered messages
`timescale 1ns/100ps
`default_nettype none

module core_handler_model (
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   // Offer from the block
   input  wire logic       deliver_valid_i,
   input  wire logic [3:0] ack_delay_i,
   // Acceptance
   output logic            deliver_ack_o
);
   logic [3:0] wait_ff;

   // One-cycle ack, so a new offer never rides on an old ack
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         wait_ff       <= 4'h0;
         deliver_ack_o <= 1'b0;
      end else begin
         deliver_ack_o <= deliver_valid_i && !deliver_ack_o && wait_ff >= ack_delay_i;
         wait_ff       <= (deliver_valid_i && !deliver_ack_o) ? wait_ff + 4'h1 : 4'h0;
      end
   end
endmodule // core_handler_model
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the local vector table and timer
`timescale 1ns/100ps
`default_nettype none

module tb;
   import vector_table_pkg::*;
   logic        sys_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sw_en = 1'b1;
   logic        li0 = 1'b0, li1 = 1'b0, eoi_v = 1'b0, offer, ack, sp_eoi, ier_wr, rps, ill;
   logic [11:0] addr = 12'h000, ier_addr;
   logic [31:0] wdata = 32'h0, rdata, ier_wdata, e_d;
   logic [7:0]  raw_id = 8'h00, eoi_vnum = 8'h00, id, sp_eoi_vnum, rpv, vnum;
   logic [3:0]  ack_dly = 4'h0;
   deliver_t    dmsg;
   msg_type_t   t;
   int          bad_count = 0, num_checks = 0, seed = 32'h4495;
   int          n_ill, n_sp_eoi, n_ier, t_last, gap, v;
   logic [10:0] exp_q[$];
   logic [7:0]  rq_q[$];
   logic [11:0] regs[8] = '{12'h320, 12'h350, 12'h360, 12'h380,
                            12'h390, 12'h3E0, 12'h410, 12'h100};
   msg_type_t   types[4] = '{MSG_FIXED, MSG_SMI, MSG_NMI, MSG_EXTINT};

   always #5 sys_clk = ~sys_clk;

   local_vector_table_and_timer dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .sw_enable_i(sw_en), .raw_identifier_i(raw_id),
      .identifier_o(id), .local_input_0_i(li0), .local_input_1_i(li1),
      .eoi_valid_i(eoi_v), .eoi_vector_i(eoi_vnum),
      .specific_end_of_interrupt_o(sp_eoi), .specific_eoi_vector_o(sp_eoi_vnum),
      .ier_wr_o(ier_wr), .ier_addr_o(ier_addr), .ier_wdata_o(ier_wdata),
      .deliver_valid_o(offer), .deliver_o(dmsg), .deliver_ack_i(ack),
      .request_pending_set_o(rps), .request_pending_vector_o(rpv),
      .illegal_vector_o(ill));

   core_handler_model core (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
      .deliver_valid_i(offer), .ack_delay_i(ack_dly), .deliver_ack_o(ack));

   // ********************
   // Shared tasks
   // ********************
   task automatic chk(input logic [31:0] got, input logic [31:0] want_v);
      num_checks++;
      if (got !== want_v) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want_v);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge sys_clk);
      wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      @(negedge sys_clk);
      rd = 1'b1;
      addr = a;
      @(negedge sys_clk);
      rd = 1'b0;
      chk(rdata, e);
   endtask

   // Model of what the core must see, vector forced to zero for SMI and NMI
   task automatic want(input msg_type_t mtype, input logic [7:0] vv);
      exp_q.push_back({mtype, (mtype == MSG_SMI || mtype == MSG_NMI) ? 8'h00 : vv});
      if (mtype == MSG_FIXED) rq_q.push_back(vv);
   endtask

   task automatic wait_q;
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 3000) begin
         @(negedge sys_clk);
         n++;
      end
      chk(exp_q.size(), 0);
   endtask

   task automatic eoi_pulse(input logic [7:0] vv);
      eoi_vnum = vv;
      eoi_v = 1'b1;
      idle(1);
      eoi_v = 1'b0;
   endtask

   task automatic pulse1;
      li1 = 1'b1;
      idle(10);
      li1 = 1'b0;
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ********************
   // Monitor: any unexpected delivery is a mismatch
   // ********************
   always @(negedge sys_clk) begin
      if (rst_n && offer === 1'b1 && ack === 1'b1) begin
         chk(dmsg, exp_q.size() > 0 ? {21'h0, exp_q.pop_front()} : 32'hFFFF_FFFF);
         gap = $time / 10 - t_last;
         t_last = $time / 10;
      end
      if (rst_n && rps === 1'b1) begin
         chk(rpv, rq_q.size() > 0 ? {24'h0, rq_q.pop_front()} : 32'hFFFF_FFFF);
      end
      if (rst_n && ill === 1'b1) n_ill++;
      if (rst_n && sp_eoi === 1'b1) n_sp_eoi++;
      if (rst_n && sp_eoi === 1'b1) chk(sp_eoi_vnum, e_d[7:0]);
      if (rst_n && ier_wr === 1'b1) n_ier++;
      if (rst_n && ier_wr === 1'b1) chk(ier_wdata, e_d);
      if (rst_n && ier_wr === 1'b1) chk(ier_addr, 32'h0000_04A0);
   end

   initial begin
      #400000;
      bad_count++;
      wrap_up;
   end

   initial begin
      t_last = 0;
      raw_id = 8'($random(seed));
      idle(8);
      rst_n = 1'b1;
      foreach (regs[i]) rd_chk(regs[i], i < 3 ? 32'h0001_0000 : 32'h0);
      for (int b = 0; b < 8; b++) begin
         wr_reg(12'h410, {29'h0, b[2:0]});
         rd_chk(12'h410, {29'h0, b[2:0]});
         chk(id, b[2] ? raw_id : {4'h0, raw_id[3:0]});
         n_sp_eoi = 0;
         n_ier = 0;
         e_d = $random(seed);
         wr_reg(12'h420, e_d);
         wr_reg(12'h4A0, e_d);
         idle(2);
         chk(n_sp_eoi, b[1]);
         chk(n_ier, b[0]);
      end
      wr_reg(12'h350, 32'hFFFF_FFFF);
      rd_chk(12'h350, 32'h0003_87FF);
      wr_reg(12'h320, 32'h0002_0030);
      for (int c = 0; c < 8; c++) begin
         v = (c == 7) ? 1 : 2 << c;
         wr_reg(12'h3E0, {28'h0, c[2], 1'b0, c[1:0]});
         want(MSG_FIXED, 8'h30);
         wr_reg(12'h380, 32'h8);
         wait_q;
         want(MSG_FIXED, 8'h30);
         wait_q;
         chk(gap, 8 * v);
         wr_reg(12'h380, 32'h0);
      end
      wr_reg(12'h320, 32'h0000_0031);
      wr_reg(12'h3E0, 32'hA);
      want(MSG_FIXED, 8'h31);
      wr_reg(12'h380, 32'h3);
      rd_chk(12'h390, 32'h3);
      wait_q;
      idle(400);
      rd_chk(12'h390, 32'h0);
      rd_chk(12'h380, 32'h3);
      wr_reg(12'h320, 32'h0003_0031);
      wr_reg(12'h3E0, 32'hB);
      wr_reg(12'h380, 32'h4);
      idle(30);
      wr_reg(12'h380, 32'h0);
      ack_dly = 4'h9;
      wr_reg(12'h350, 32'h0000_8040);
      want(MSG_FIXED, 8'h40);
      li0 = 1'b1;
      wait_q;
      rd_chk(12'h350, 32'h0000_C040);
      idle(20);
      want(MSG_FIXED, 8'h40);
      eoi_pulse(8'h40);
      wait_q;
      li0 = 1'b0;
      eoi_pulse(8'h40);
      rd_chk(12'h350, 32'h0000_8040);
      for (int k = 0; k < 4; k++) begin
         t = types[k];
         vnum = 8'(16 + $unsigned($random(seed)) % 240);
         e_d = {16'h0, t != MSG_FIXED, 4'h0, t, vnum};
         wr_reg(12'h360, e_d);
         want(t, vnum);
         li1 = 1'b1;
         wait_q;
         idle(10);
         rd_chk(12'h360, e_d);
         li1 = 1'b0;
      end
      wr_reg(12'h360, 32'h0000_0005);
      n_ill = 0;
      pulse1;
      chk(n_ill, 1);
      wr_reg(12'h360, 32'h0001_0005);
      pulse1;
      chk(n_ill, 1);
      sw_en = 1'b0;
      wr_reg(12'h360, 32'h0000_0050);
      rd_chk(12'h360, 32'h0001_0050);
      sw_en = 1'b1;
      chk(exp_q.size() + rq_q.size(), 0);
      wrap_up;
   end
endmodule // tb
`default_nettype wire
